// ===== src/acc_pkg.sv
package acc_pkg;
    localparam logic [5:0]  ADDR_HIGH       = 6'h09;
    localparam int          CLK_MHZ         = 250;
    localparam int          POR_US          = 350;
    localparam int          POR_CYC         = POR_US * CLK_MHZ;
    localparam int          STARTUP_MS      = 2;
    localparam int          STARTUP_CYC     = STARTUP_MS * 1000 * CLK_MHZ;
    localparam int          WAKE_MS         = 1;
    localparam int          WAKE_CYC        = WAKE_MS * 1000 * CLK_MHZ;
    localparam logic [7:0]  REG_MODE        = 8'h11;
    localparam int          MODE_BIT        = 7;
    localparam logic [7:0]  REG_REINIT      = 8'h36;
    localparam logic [7:0]  REINIT_CODE     = 8'hB6;
    localparam logic [7:0]  REG_RATE        = 8'h10;
    localparam int          RATE_HI_BIT     = 5;
    localparam logic [7:0]  REG_DATA0       = 8'h01;
    localparam logic [7:0]  MODE_RST        = 8'h00;
    localparam logic [7:0]  RATE_RST        = 8'h00;
    localparam int          ADC_BITS        = 10;
    localparam int          RATE_MULT       = 4;
    localparam int          BW_CYC          = 100000;
endpackage : acc_pkg

// ===== src/acc_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acc_sync_if;
    logic scl;
    logic sda;
    logic strap;
    modport src (output scl, output sda, output strap);
    modport dst (input scl, input sda, input strap);
endinterface : acc_sync_if
`default_nettype wire

// ===== src/acc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage samplers; a change counts when stages two and three agree
module acc_sync
(
    input  wire logic    clk_sys_in,
    input  wire logic    rst_b_in,
    input  wire logic    scl_in,
    input  wire logic    sda_in,
    input  wire logic    strap_in,
    acc_sync_if.src      sy
);
    logic [2:0] s0;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] q;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            s0 <= 3'h3;
            s1 <= 3'h3;
            s2 <= 3'h3;
            q  <= 3'h3;
        end
        else
        begin
            s0 <= {strap_in, sda_in, scl_in};
            s1 <= s0;
            s2 <= s1;
            for (int i = 0; i < 3; i++)
                if (s1[i] == s2[i])
                    q[i] <= s2[i];
        end
    end
    assign sy.scl   = q[0];
    assign sy.sda   = q[1];
    assign sy.strap = q[2];
endmodule : acc_sync
`default_nettype wire

// ===== src/acc_front.sv
// Functional notes
// - device is only an i2c target; the master starts every access
// - seven-bit address: six fixed high bits, low bit from strap pin
// - strap low answers 0010010, strap high answers 0010011
// - bus logic works at 100 kHz and 400 kHz; master stays within 400 kHz
// - power-on reset restores register defaults then enters standby
// - power-on sequence done within 350 us; master waits that long
// - conversions ready about 2 ms after supply settles
// - active mode ready to convert about 1 ms after leaving standby
// - high-rate option samples at four times bandwidth
// - each axis sample carries ten significant bits
// - all logic runs on internal clock; no clock in or out
// - writing reinit code restores defaults and standby in any mode
// - mode bit one enters active, zero returns to standby
`timescale 1ns/1ps
`default_nettype none
module acc_front
#(
    parameter int POR_CYC     = acc_pkg::POR_CYC,
    parameter int STARTUP_CYC = acc_pkg::STARTUP_CYC,
    parameter int WAKE_CYC    = acc_pkg::WAKE_CYC,
    parameter int BW_CYC      = acc_pkg::BW_CYC
)
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        addr_lsb_strap_in,
    input  wire logic [29:0] axis_data_in,
    output logic             sda_out,
    output logic             sda_oe_b_out,
    output logic             bus_ready_out,
    output logic             active_out,
    output logic             conv_ready_out,
    output logic             sample_strobe_out,
    output logic             high_rate_select_out
);
    typedef enum logic [2:0]
    {
        ACC_IDLE = 3'b000,
        ACC_ADDR = 3'b001,
        ACC_ACK  = 3'b010,
        ACC_WR   = 3'b011,
        ACC_RD   = 3'b100,
        ACC_RACK = 3'b101,
        ACC_SKIP = 3'b110
    } acc_state_e;

    acc_sync_if sy ();
    acc_sync u_sync
    (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .strap_in   (addr_lsb_strap_in),
        .sy         (sy.src)
    );

    acc_state_e  st;
    logic        scl_d;
    logic        sda_d;
    logic [7:0]  shreg;
    logic [3:0]  bitn;
    logic        rw;
    logic [1:0]  wbyte;
    logic [7:0]  ptr;
    logic [7:0]  mode_reg;
    logic [7:0]  rate_reg;
    logic [31:0] por_cnt;
    logic [31:0] up_cnt;
    logic [31:0] wake_cnt;
    logic [31:0] conv_cnt;
    logic        drive_low;
    logic        por_done;
    logic [6:0]  my_addr;
    logic [59:0] samp;

    wire scl_rise  = sy.scl & ~scl_d;
    wire scl_fall  = ~sy.scl & scl_d;
    wire start_cnd = sy.scl & scl_d & sda_d & ~sy.sda;
    wire stop_cnd  = sy.scl & scl_d & ~sda_d & sy.sda;
    // address is six fixed bits plus strap
    assign my_addr = {acc_pkg::ADDR_HIGH, sy.strap};
    wire addr_hit  = (shreg[7:1] == my_addr);
    wire wr_reinit = (ptr == acc_pkg::REG_REINIT) && (shreg == acc_pkg::REINIT_CODE);
    wire mode_on   = mode_reg[acc_pkg::MODE_BIT];
    wire rate_hi   = rate_reg[acc_pkg::RATE_HI_BIT];
    // conversion period is bandwidth period divided by four when high rate
    wire [31:0] conv_per = rate_hi ? 32'(BW_CYC / acc_pkg::RATE_MULT) : 32'(BW_CYC);

    function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [59:0] s,
        input logic [7:0] m, input logic [7:0] t);
        logic [7:0] r;
        r = 8'h00;
        // ten-bit samples, left-justified low byte holds two lsbs
        case (a)
            8'h01:   r = {s[1:0], 6'h00};
            8'h02:   r = s[9:2];
            8'h03:   r = {s[11:10], 6'h00};
            8'h04:   r = s[19:12];
            8'h05:   r = {s[21:20], 6'h00};
            8'h06:   r = s[29:22];
            acc_pkg::REG_MODE: r = m;
            acc_pkg::REG_RATE: r = t;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : rd_byte
    // byte to be shifted out next, at the current pointer
    wire [7:0] rd_next = rd_byte(ptr, samp, mode_reg, rate_reg);

    // power-on sequence timer gates the bus until done
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            por_cnt <= 32'h0;
        else if (!por_done)
            por_cnt <= por_cnt + 32'h1;
    end
    assign por_done = (por_cnt >= 32'(POR_CYC));

    // startup and wakeup timing
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            up_cnt   <= 32'h0;
            wake_cnt <= 32'h0;
        end
        else
        begin
            if (up_cnt < 32'(STARTUP_CYC))
                up_cnt <= up_cnt + 32'h1;
            if (!mode_on)
                wake_cnt <= 32'h0;
            else if (wake_cnt < 32'(WAKE_CYC))
                wake_cnt <= wake_cnt + 32'h1;
        end
    end
    wire ready_int = mode_on && (up_cnt >= 32'(STARTUP_CYC)) && (wake_cnt >= 32'(WAKE_CYC));

    // sample capture at the selected rate
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            conv_cnt          <= 32'h0;
            samp              <= 60'h0;
            sample_strobe_out <= 1'b0;
        end
        else
        begin
            sample_strobe_out <= 1'b0;
            if (!ready_int)
                conv_cnt <= 32'h0;
            else if (conv_cnt + 32'h1 >= conv_per)
            begin
                conv_cnt          <= 32'h0;
                sample_strobe_out <= 1'b1;
                if (st == ACC_IDLE)
                    samp <= {30'h0, axis_data_in};
            end
            else
                conv_cnt <= conv_cnt + 32'h1;
        end
    end

    // i2c target engine; timing by oversampling so both bus speeds work
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            st        <= ACC_IDLE;
            scl_d     <= 1'b1;
            sda_d     <= 1'b1;
            shreg     <= 8'h00;
            bitn      <= 4'h0;
            rw        <= 1'b0;
            wbyte     <= 2'h0;
            ptr       <= 8'h00;
            drive_low <= 1'b0;
            mode_reg  <= acc_pkg::MODE_RST;
            rate_reg  <= acc_pkg::RATE_RST;
        end
        else
        begin
            scl_d <= sy.scl;
            sda_d <= sy.sda;
            if (!por_done || stop_cnd)
            begin
                st        <= ACC_IDLE;
                drive_low <= 1'b0;
            end
            else if (start_cnd)
            begin
                st        <= ACC_ADDR;
                bitn      <= 4'h0;
                wbyte     <= 2'h0;
                drive_low <= 1'b0;
            end
            else
            begin
                case (st)
                    ACC_IDLE: drive_low <= 1'b0;
                    ACC_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sy.sda};
                            bitn  <= bitn + 4'h1;
                        end
                        if (scl_fall && bitn == 4'h8)
                        begin
                            if (addr_hit)
                            begin
                                st        <= ACC_ACK;
                                rw        <= shreg[0];
                                drive_low <= 1'b1;
                            end
                            else
                                st <= ACC_SKIP;
                        end
                    end
                    ACC_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bitn <= 4'h0;
                            if (rw)
                            begin
                                st        <= ACC_RD;
                                shreg     <= rd_next;
                                drive_low <= ~rd_next[7];
                                ptr       <= ptr + 8'h1;
                            end
                            else
                            begin
                                st        <= ACC_WR;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    ACC_WR:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sy.sda};
                            bitn  <= bitn + 4'h1;
                        end
                        if (scl_fall && bitn == 4'h8)
                        begin
                            st        <= ACC_ACK;
                            drive_low <= 1'b1;
                            if (wbyte == 2'h0)
                            begin
                                ptr   <= shreg;
                                wbyte <= 2'h1;
                            end
                            else
                            begin
                                ptr <= ptr + 8'h1;
                                if (wr_reinit)
                                begin
                                    mode_reg <= acc_pkg::MODE_RST;
                                    rate_reg <= acc_pkg::RATE_RST;
                                end
                                else if (ptr == acc_pkg::REG_MODE)
                                    mode_reg <= shreg;
                                else if (ptr == acc_pkg::REG_RATE)
                                    rate_reg <= shreg;
                            end
                        end
                    end
                    ACC_RD:
                    begin
                        if (scl_fall)
                        begin
                            if (bitn == 4'h7)
                            begin
                                st        <= ACC_RACK;
                                drive_low <= 1'b0;
                            end
                            else
                            begin
                                shreg     <= {shreg[6:0], 1'b0};
                                drive_low <= ~shreg[6];
                                bitn      <= bitn + 4'h1;
                            end
                        end
                    end
                    ACC_RACK:
                    begin
                        if (scl_rise)
                            rw <= ~sy.sda;
                        if (scl_fall)
                        begin
                            bitn <= 4'h0;
                            if (rw)
                            begin
                                st        <= ACC_RD;
                                shreg     <= rd_next;
                                drive_low <= ~rd_next[7];
                                ptr       <= ptr + 8'h1;
                            end
                            else
                                st <= ACC_SKIP;
                        end
                    end
                    ACC_SKIP: drive_low <= 1'b0;
                    default:  st <= ACC_IDLE;
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_out              = 1'b0;
    assign sda_oe_b_out         = ~drive_low;
    assign bus_ready_out        = por_done;
    assign active_out           = mode_on;
    assign conv_ready_out       = ready_int;
    assign high_rate_select_out = rate_hi;
endmodule : acc_front
`default_nettype wire

// ===== test/acc_front_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acc_front_asserts
#(
    parameter int POR_CYC     = 50,
    parameter int STARTUP_CYC = 100,
    parameter int WAKE_CYC    = 100,
    parameter int BW_CYC      = 40
)
(
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic sda_out,
    input  wire logic sda_oe_b_out,
    input  wire logic bus_ready_out,
    input  wire logic active_out,
    input  wire logic conv_ready_out,
    input  wire logic sample_strobe_out,
    input  wire logic high_rate_select_out
);
    int   cnt;
    int   act_cnt;
    int   gap;
    logic seen;
    logic hr_q;
    logic act_q;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    // cycles since reset release, since activation, since last strobe
    always_ff @(posedge clk_sys_in)
    begin
        cnt     <= !rst_b_in ? 0 : (cnt < 1000000 ? cnt + 1 : cnt);
        act_cnt <= !active_out ? 0 : (act_cnt < 1000000 ? act_cnt + 1 : act_cnt);
        gap     <= (!rst_b_in || sample_strobe_out) ? 1 : gap + 1;
        hr_q    <= high_rate_select_out;
        act_q   <= active_out;
        if (!rst_b_in || hr_q != high_rate_select_out || act_q != active_out)
            seen <= 1'b0;
        else if (sample_strobe_out)
            seen <= 1'b1;
    end
    a_sda_open_drain: assert property (!sda_oe_b_out |-> !sda_out)
        else $error("sda driven high");
    a_por_early_quiet: assert property (cnt < POR_CYC - 2 |-> !bus_ready_out)
        else $error("bus ready too early");
    a_por_done_ready: assert property (cnt > POR_CYC + 4 |-> bus_ready_out)
        else $error("bus ready too late");
    a_bus_quiet_por: assert property (!bus_ready_out |-> sda_oe_b_out)
        else $error("sda pulled before bus ready");
    a_por_standby: assert property ($rose(bus_ready_out) |->
        !active_out && !high_rate_select_out && !conv_ready_out)
        else $error("not in standby after power on");
    a_conv_needs_active: assert property (conv_ready_out |-> active_out)
        else $error("ready while in standby");
    a_wake_hold: assert property (active_out && act_cnt < WAKE_CYC - 4 |-> !conv_ready_out)
        else $error("ready before wakeup time");
    a_wake_bound: assert property (active_out && act_cnt > WAKE_CYC + 4
        && cnt > STARTUP_CYC + 4 |-> conv_ready_out)
        else $error("not ready after wakeup time");
    a_strobe_pulse: assert property (sample_strobe_out |=> !sample_strobe_out [*3])
        else $error("strobe longer than one cycle");
    a_rate_gap: assert property (sample_strobe_out && seen && hr_q == high_rate_select_out
        && act_q == active_out |->
        gap == (high_rate_select_out ? BW_CYC / acc_pkg::RATE_MULT : BW_CYC))
        else $error("sample period wrong");
endmodule : acc_front_asserts
`default_nettype wire

// ===== test/acc_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module acc_i2c_master
#(
    parameter int Q = 3
)
(
    input  wire logic clk_sys_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // idle: both lines released to the pull-ups, scl stands still
    initial
    begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic q(input int n);
        repeat (n * Q) @(negedge clk_sys_in);
    endtask : q
    // master alone starts and stops every frame
    task automatic start();
        sda_low_out = 1'b0;
        q(1);
        scl_out = 1'b1;
        q(1);
        sda_low_out = 1'b1;
        q(1);
        scl_out = 1'b0;
        q(1);
    endtask : start
    task automatic stop();
        sda_low_out = 1'b1;
        q(1);
        scl_out = 1'b1;
        q(1);
        sda_low_out = 1'b0;
        q(1);
    endtask : stop
    // one bit slot of 4*Q cycles; scl high and low for 2*Q cycles each
    task automatic bit_io(input logic b, output logic s);
        sda_low_out = !b;
        q(1);
        scl_out = 1'b1;
        q(1);
        s = sda_in;
        q(1);
        scl_out = 1'b0;
        q(1);
    endtask : bit_io
    // eight bits msb first, then the acknowledge slot; nak is the line level seen
    task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
        output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(a, nak);
    endtask : byte_io
endmodule : acc_i2c_master
`default_nettype wire

// ===== test/test_accel_i2c_slave_por_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module test_accel_i2c_slave_por_front_end;
    localparam int         POR = 50;
    localparam int         BW  = 40;
    localparam logic [9:0] X   = 10'h2C5;
    logic        clk_sys_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        strap      = 1'b0;
    logic [29:0] axis       = {10'h155, 10'h0AA, X};
    wire  logic  scl;
    wire  logic  m_low;
    logic        sda_out, sda_oe_b, bus_ready, active, conv_ready, strobe, high_rate;
    wire  logic  sda_line = !(m_low || (sda_oe_b === 1'b0 && sda_out === 1'b0));
    int          failures = 0;
    int          checks   = 0;
    always #2 clk_sys_in = !clk_sys_in;
    acc_front #(.POR_CYC(POR), .STARTUP_CYC(100), .WAKE_CYC(100), .BW_CYC(BW)) u_acc_front (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_line),
        .addr_lsb_strap_in(strap), .axis_data_in(axis), .sda_out(sda_out),
        .sda_oe_b_out(sda_oe_b), .bus_ready_out(bus_ready), .active_out(active),
        .conv_ready_out(conv_ready), .sample_strobe_out(strobe),
        .high_rate_select_out(high_rate));
    acc_i2c_master #(.Q(3)) u_acc_i2c_master (.clk_sys_in(clk_sys_in), .sda_in(sda_line),
        .scl_out(scl), .sda_low_out(m_low));
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic wr(input logic a, input logic [7:0] p, input logic [7:0] d,
        output logic nak);
        logic [7:0] r;
        logic       k;
        u_acc_i2c_master.start();
        u_acc_i2c_master.byte_io({acc_pkg::ADDR_HIGH, a, 1'b0}, 1'b1, r, nak);
        if (!nak)
        begin
            u_acc_i2c_master.byte_io(p, 1'b1, r, k);
            u_acc_i2c_master.byte_io(d, 1'b1, r, k);
        end
        u_acc_i2c_master.stop();
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] r);
        logic k;
        u_acc_i2c_master.start();
        u_acc_i2c_master.byte_io({acc_pkg::ADDR_HIGH, 2'b00}, 1'b1, r, k);
        u_acc_i2c_master.byte_io(p, 1'b1, r, k);
        u_acc_i2c_master.start();
        u_acc_i2c_master.byte_io({acc_pkg::ADDR_HIGH, 2'b01}, 1'b1, r, k);
        u_acc_i2c_master.byte_io(8'hFF, 1'b1, r, k);
        u_acc_i2c_master.stop();
    endtask : rd
    task automatic wait_strobe(output int n);
        n = 0;
        while (strobe !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        @(negedge clk_sys_in);
        n = 1;
        while (strobe !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask : wait_strobe
    task automatic t_reset();
        repeat (15) @(negedge clk_sys_in);
        check("oe_b in reset", sda_oe_b, 1'b1);
        check("active in reset", active, 1'b0);
        @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        repeat (POR / 2) @(negedge clk_sys_in);
        check("bus ready early", bus_ready, 1'b0);
        repeat (POR) @(negedge clk_sys_in);
        check("bus ready", bus_ready, 1'b1);
    endtask : t_reset
    task automatic t_addr();
        logic nak;
        for (int s = 0; s < 2; s++)
        begin
            strap = s[0];
            repeat (8) @(negedge clk_sys_in);
            for (int a = 0; a < 2; a++)
            begin
                wr(a[0], acc_pkg::REG_MODE, acc_pkg::MODE_RST, nak);
                check("address nak", nak, a != s);
            end
        end
        strap = 1'b0;
    endtask : t_addr
    task automatic t_active();
        logic       nak;
        logic [7:0] r;
        int         n;
        wr(1'b0, acc_pkg::REG_MODE, 8'h80, nak);
        check("active", active, 1'b1);
        check("ready at wake", conv_ready, 1'b0);
        repeat (120) @(negedge clk_sys_in);
        check("ready after wake", conv_ready, 1'b1);
        wait_strobe(n);
        check("period", 10'(n), 10'(BW));
        wr(1'b0, acc_pkg::REG_RATE, 8'h20, nak);
        check("high rate", high_rate, 1'b1);
        wait_strobe(n);
        check("fast period", 10'(n), 10'(BW / acc_pkg::RATE_MULT));
        rd(acc_pkg::REG_DATA0, r);
        check("x low", r, {X[1:0], 6'h00});
        rd(acc_pkg::REG_DATA0 + 8'h01, r);
        check("x high", r, X[9:2]);
    endtask : t_active
    task automatic t_reinit();
        logic nak;
        wr(1'b0, acc_pkg::REG_REINIT, acc_pkg::REINIT_CODE, nak);
        check("active after reinit", active, 1'b0);
        check("rate after reinit", high_rate, 1'b0);
        wr(1'b0, acc_pkg::REG_MODE, 8'h80, nak);
        check("active again", active, 1'b1);
        wr(1'b0, acc_pkg::REG_MODE, 8'h00, nak);
        check("standby", active, 1'b0);
    endtask : t_reinit
    initial
    begin
        t_reset();
        t_addr();
        t_active();
        t_reinit();
        end_sim();
    end
    initial
    begin
        #100000;
        failures++;
        end_sim();
    end
endmodule : test_accel_i2c_slave_por_front_end
bind acc_front acc_front_asserts #(.POR_CYC(POR_CYC), .STARTUP_CYC(STARTUP_CYC),
    .WAKE_CYC(WAKE_CYC), .BW_CYC(BW_CYC)) u_acc_front_asserts (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sda_out(sda_out),
    .sda_oe_b_out(sda_oe_b_out), .bus_ready_out(bus_ready_out), .active_out(active_out),
    .conv_ready_out(conv_ready_out), .sample_strobe_out(sample_strobe_out),
    .high_rate_select_out(high_rate_select_out));
`default_nettype wire
